// >>> lofc_cfg.svh
/*
  Offsets, field positions, reset values and timing counts for the LVDS
  output format block. Assumes inclusion by the package and design files.
*/
`ifndef LOFC_CFG_SVH
`define LOFC_CFG_SVH
`define LOFC_ADDR_W          8
`define LOFC_OFS_FORMAT      8'h18
`define LOFC_OFS_LEVEL       8'h19
`define LOFC_OFS_CHAN_MODE   8'h1C
`define LOFC_OFS_STATUS      8'h1D
`define LOFC_FORMAT_RST      8'h70
`define LOFC_LEVEL_RST       8'h05
`define LOFC_LEVEL_MASK      8'h5F
`define LOFC_CHAN_MODE_RST   2'h1
`define LOFC_BIT_DE_INV      7
`define LOFC_BIT_HS_INV      6
`define LOFC_BIT_VS_INV      5
`define LOFC_BIT_SINGLE      4
`define LOFC_BIT_A_WIDE      3
`define LOFC_BIT_B_WIDE      2
`define LOFC_BIT_A_LSB       1
`define LOFC_BIT_B_LSB       0
`define LOFC_BIT_A_LOW_CM    6
`define LOFC_BIT_B_LOW_CM    4
`define LOFC_FIFO_DEPTH      32
`define LOFC_CLK_NS          25
`define LOFC_LINK_CLK_NS     200
`define LOFC_LINK_CYC        (`LOFC_LINK_CLK_NS / `LOFC_CLK_NS)
`endif

// >>> lofc_pkg.sv
/*
  Types for the LVDS output format block.
  Assumes lofc_cfg.svh is on the include path.
*/
`include "lofc_cfg.svh"
package lofc_pkg;
  // Input channel arrangement
  typedef enum logic [1:0] {
    LOFC_IN_DUAL   = 2'h0,
    LOFC_IN_SINGLE = 2'h1,
    LOFC_IN_TWO    = 2'h2,
    LOFC_IN_RSVD   = 2'h3
  } lofc_in_mode_t;

  // Link operating state, one-hot
  typedef enum logic [2:0] {
    LOFC_LINK_SINGLE = 3'h1,
    LOFC_LINK_DUAL   = 3'h2,
    LOFC_LINK_TWO    = 3'h4
  } lofc_link_t;

  // One 24-bit pixel with its timing flags
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic       data_enable;
    logic       hsync;
    logic       vsync;
  } lofc_pixel_t;

  // One channel's output word
  typedef struct packed {
    logic [17:0] base_lanes;
    logic [5:0]  fourth_lane;
    logic        fourth_lane_en;
    logic        chan_en;
    logic        data_enable;
    logic        hsync;
    logic        vsync;
  } lofc_chan_out_t;
endpackage : lofc_pkg

// >>> lofc_top.sv
/*
  LVDS output format configuration: register file, pixel FIFO and the
  per-channel formatting of polarity, link mode and colour depth.
  Assumes a 40 MHz system clock, a link clock sampled as a plain input,
  and a register master that never needs wait states.
*/
// Our own choice: strobed register access.
// Contract
// - Bit 7 inverts data enable polarity
// - Bit 6 inverts hsync, reset inverted
// - Bit 5 inverts vsync, reset inverted
// - Link bit 0, dual/single input: dual-link
// - Link bit 0, two inputs: two single links
// - Link bit 1: only channel A enabled
// - Bit 3: channel A 24bpp, fourth lane on
// - Bit 2: channel B 24bpp, fourth lane on
// - Bit 1: channel A LSBs on fourth lane
// - Bit 0: channel B LSBs on fourth lane
// - Format 1, 18bpp: drop two LSBs
// - Level bits 6, 4 select low common mode
// - Swing fields 3:2, 1:0 reset 01
// - Arrangement 00 dual, 01 single, 10 two
`timescale 1ns/10ps
`default_nettype none
`include "lofc_cfg.svh"

module lofc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that the wrapping pointers cannot count
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("lofc_fifo: DEPTH must be a power of two");
  end

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } lofc_fifo_state_t;

  lofc_fifo_state_t st_ff;
  lofc_fifo_state_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // One extra pointer bit tells full from empty
  assign in_ready_out  = (st_ff.wr_ptr - st_ff.rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_out = st_ff.wr_ptr != st_ff.rd_ptr;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem[st_ff.rd_ptr[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
    if (pop) nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
  end

  // Storage needs no reset: only words behind the write pointer are read
  always_ff @(posedge clk_in) begin
    if (push) mem[st_ff.wr_ptr[AW-1:0]] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : lofc_fifo

module lofc_top
  import lofc_pkg::*;
#(
  parameter int FIFO_DEPTH = `LOFC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // Pixel source
  input  wire logic        pix_valid_in,
  input  wire lofc_pixel_t pix_a_in,
  input  wire lofc_pixel_t pix_b_in,
  output logic             pix_ready_out,
  // Link side
  input  wire logic        link_clk_in,
  output lofc_chan_out_t   chan_a_out,
  output lofc_chan_out_t   chan_b_out,
  output logic [1:0]       chan_a_swing_level_out,
  output logic [1:0]       chan_b_swing_level_out,
  output logic             chan_a_low_common_mode_out,
  output logic             chan_b_low_common_mode_out,
  output lofc_link_t       link_state_out
);
  localparam int PW = $bits(lofc_pixel_t);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("lofc_top: FIFO_DEPTH too small");
  end

  typedef struct packed {
    logic [7:0]     format;
    logic [7:0]     level;
    lofc_in_mode_t  in_mode;
    logic [7:0]     rdata;
    logic           lclk_s1;
    logic           lclk_s2;
    logic           lclk_s3;
    lofc_link_t     link;
    lofc_chan_out_t out_a;
    lofc_chan_out_t out_b;
  } lofc_state_t;

  lofc_state_t st_ff;
  lofc_state_t nxt_st;

  logic [2*PW-1:0] fifo_out;
  logic            fifo_valid;
  logic            link_rise;
  lofc_pixel_t     pa;
  lofc_pixel_t     pb;

  lofc_fifo #(.WIDTH(2*PW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (pix_valid_in),
    .in_data_in    ({pix_a_in, pix_b_in}),
    .in_ready_out  (pix_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_out),
    .out_ready_in  (link_rise)
  );

  assign link_rise = st_ff.lclk_s2 && !st_ff.lclk_s3;
  assign pa        = fifo_out[2*PW-1:PW];
  assign pb        = fifo_out[PW-1:0];

  // Builds one channel word from a pixel and that channel's settings
  function automatic lofc_chan_out_t fmt_chan(input lofc_pixel_t p, input logic en,
                                              input logic wide, input logic lsb_fmt,
                                              input logic [7:0] f, input logic vld);
    lofc_chan_out_t o;
    o = '0;
    o.chan_en = en;
    if (en && vld) begin
      // Format 1 keeps the six MSBs on the base lanes, which is also the
      // 24-to-18 reduction when the fourth lane is off
      if (lsb_fmt) begin
        o.base_lanes  = {p.red[7:2], p.green[7:2], p.blue[7:2]};
        o.fourth_lane = {p.red[1:0], p.green[1:0], p.blue[1:0]};
      end else begin
        o.base_lanes  = {p.red[5:0], p.green[5:0], p.blue[5:0]};
        o.fourth_lane = {p.red[7:6], p.green[7:6], p.blue[7:6]};
      end
      if (!wide) o.fourth_lane = '0;
    end
    o.fourth_lane_en = en && wide;
    o.data_enable    = (en && vld && p.data_enable) ^ f[`LOFC_BIT_DE_INV];
    o.hsync          = (en && vld && p.hsync) ^ f[`LOFC_BIT_HS_INV];
    o.vsync          = (en && vld && p.vsync) ^ f[`LOFC_BIT_VS_INV];
    return o;
  endfunction : fmt_chan

  always_comb begin
    nxt_st = st_ff;
    nxt_st.lclk_s1 = link_clk_in;
    nxt_st.lclk_s2 = st_ff.lclk_s1;
    nxt_st.lclk_s3 = st_ff.lclk_s2;
    if (reg_wr_in) begin
      if (reg_addr_in == `LOFC_OFS_FORMAT) begin
        nxt_st.format = reg_wdata_in;
      end else if (reg_addr_in == `LOFC_OFS_LEVEL) begin
        nxt_st.level = reg_wdata_in & `LOFC_LEVEL_MASK;
      end else if (reg_addr_in == `LOFC_OFS_CHAN_MODE) begin
        nxt_st.in_mode = lofc_in_mode_t'(reg_wdata_in[1:0]);
      end
    end
    nxt_st.rdata = 8'h00;
    if (reg_rd_in) begin
      if (reg_addr_in == `LOFC_OFS_FORMAT) begin
        nxt_st.rdata = st_ff.format;
      end else if (reg_addr_in == `LOFC_OFS_LEVEL) begin
        nxt_st.rdata = st_ff.level;
      end else if (reg_addr_in == `LOFC_OFS_CHAN_MODE) begin
        nxt_st.rdata = {6'h00, st_ff.in_mode};
      end else if (reg_addr_in == `LOFC_OFS_STATUS) begin
        nxt_st.rdata = {4'h0, fifo_valid, st_ff.link};
      end
    end
    case (1'b1)
      st_ff.format[`LOFC_BIT_SINGLE]: nxt_st.link = LOFC_LINK_SINGLE;
      st_ff.in_mode == LOFC_IN_TWO:   nxt_st.link = LOFC_LINK_TWO;
      default:                        nxt_st.link = LOFC_LINK_DUAL;
    endcase
    if (link_rise) begin
      nxt_st.out_a = fmt_chan(pa, 1'b1, st_ff.format[`LOFC_BIT_A_WIDE],
                              st_ff.format[`LOFC_BIT_A_LSB], st_ff.format, fifo_valid);
      // Channel B sends its own pix_b_in pixel in dual and two-link alike, and is off in single link
      nxt_st.out_b = fmt_chan(pb, st_ff.link != LOFC_LINK_SINGLE,
                              st_ff.format[`LOFC_BIT_B_WIDE],
                              st_ff.format[`LOFC_BIT_B_LSB], st_ff.format, fifo_valid);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff         <= '0;
      st_ff.format  <= `LOFC_FORMAT_RST;
      st_ff.level   <= `LOFC_LEVEL_RST;
      st_ff.in_mode <= lofc_in_mode_t'(`LOFC_CHAN_MODE_RST);
      st_ff.link    <= LOFC_LINK_SINGLE;
      st_ff.out_a   <= '{default: 1'b0, chan_en: 1'b1, hsync: 1'b1, vsync: 1'b1};
      st_ff.out_b   <= '{default: 1'b0, hsync: 1'b1, vsync: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out              = st_ff.rdata;
  assign chan_a_out                 = st_ff.out_a;
  assign chan_b_out                 = st_ff.out_b;
  assign link_state_out             = st_ff.link;
  assign chan_a_swing_level_out     = st_ff.level[3:2];
  assign chan_b_swing_level_out     = st_ff.level[1:0];
  assign chan_a_low_common_mode_out = st_ff.level[`LOFC_BIT_A_LOW_CM];
  assign chan_b_low_common_mode_out = st_ff.level[`LOFC_BIT_B_LOW_CM];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_single_link_b_off: assert property (
    link_rise && st_ff.format[`LOFC_BIT_SINGLE] && st_ff.link == LOFC_LINK_SINGLE
    |=> !chan_b_out.chan_en)
    else $error("channel B enabled in single link");
  a_dual_link_mode: assert property (
    !st_ff.format[`LOFC_BIT_SINGLE] && st_ff.in_mode != LOFC_IN_TWO |=> link_state_out == LOFC_LINK_DUAL)
    else $error("dual link not selected");
  a_two_link_mode: assert property (
    !st_ff.format[`LOFC_BIT_SINGLE] && st_ff.in_mode == LOFC_IN_TWO |=> link_state_out == LOFC_LINK_TWO)
    else $error("two single links not selected");
  a_lane_a_gate: assert property (
    link_rise ##1 1'b1 |-> chan_a_out.fourth_lane_en == $past(st_ff.format[`LOFC_BIT_A_WIDE]))
    else $error("channel A fourth lane enable wrong");
  a_lane_b_gate: assert property (
    link_rise && st_ff.link != LOFC_LINK_SINGLE |=>
    chan_b_out.fourth_lane_en == $past(st_ff.format[`LOFC_BIT_B_WIDE]))
    else $error("channel B fourth lane enable wrong");
  a_de_idle_level: assert property (
    link_rise && !fifo_valid |=> chan_a_out.data_enable == $past(st_ff.format[`LOFC_BIT_DE_INV]))
    else $error("data enable idle level wrong");
  a_sync_idle_level: assert property (
    link_rise && !fifo_valid |=> chan_a_out.hsync == $past(st_ff.format[`LOFC_BIT_HS_INV])
    && chan_a_out.vsync == $past(st_ff.format[`LOFC_BIT_VS_INV]))
    else $error("sync idle level wrong");
  a_lsb_on_lane_a: assert property (
    link_rise && fifo_valid && st_ff.format[`LOFC_BIT_A_WIDE] && st_ff.format[`LOFC_BIT_A_LSB]
    |=> chan_a_out.fourth_lane[1:0] == $past(pa.blue[1:0]))
    else $error("channel A LSB lane format wrong");
  a_reduce_drop_lsb: assert property (
    link_rise && fifo_valid && !st_ff.format[`LOFC_BIT_A_WIDE] && st_ff.format[`LOFC_BIT_A_LSB]
    |=> chan_a_out.base_lanes[5:0] == $past(pa.blue[7:2]) && chan_a_out.fourth_lane == 6'h00)
    else $error("24 to 18 reduction wrong");
  a_level_reserved: assert property (
    reg_rd_in && reg_addr_in == `LOFC_OFS_LEVEL |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[5] == 1'b0)
    else $error("reserved level bits not zero");
  a_msb_lane_a: assert property (
    link_rise && fifo_valid && st_ff.format[`LOFC_BIT_A_WIDE] && !st_ff.format[`LOFC_BIT_A_LSB]
    |=> chan_a_out.fourth_lane[5:4] == $past(pa.red[7:6]))
    else $error("channel A MSB lane format wrong");
  a_lsb_lane_b: assert property (
    link_rise && fifo_valid && st_ff.link != LOFC_LINK_SINGLE && st_ff.format[`LOFC_BIT_B_WIDE]
    && st_ff.format[`LOFC_BIT_B_LSB] |=> chan_b_out.fourth_lane[1:0] == $past(pb.blue[1:0]))
    else $error("channel B LSB lane format wrong");
  a_msb_lane_b: assert property (
    link_rise && fifo_valid && st_ff.link != LOFC_LINK_SINGLE && st_ff.format[`LOFC_BIT_B_WIDE]
    && !st_ff.format[`LOFC_BIT_B_LSB] |=> chan_b_out.fourth_lane[5:4] == $past(pb.red[7:6]))
    else $error("channel B MSB lane format wrong");
  a_reduce_lane_b: assert property (
    link_rise && fifo_valid && st_ff.link != LOFC_LINK_SINGLE && !st_ff.format[`LOFC_BIT_B_WIDE]
    && st_ff.format[`LOFC_BIT_B_LSB] |=> chan_b_out.base_lanes[17:12] == $past(pb.red[7:2])
    && chan_b_out.fourth_lane == 6'h00)
    else $error("channel B 24 to 18 reduction wrong");
  a_de_active_level: assert property (
    link_rise && fifo_valid && pa.data_enable
    |=> chan_a_out.data_enable == !$past(st_ff.format[`LOFC_BIT_DE_INV]))
    else $error("data enable active level wrong");
  a_hsync_active_level: assert property (
    link_rise && fifo_valid && pa.hsync
    |=> chan_a_out.hsync == !$past(st_ff.format[`LOFC_BIT_HS_INV]))
    else $error("hsync active level wrong");
  a_vsync_active_level: assert property (
    link_rise && fifo_valid && pa.vsync
    |=> chan_a_out.vsync == !$past(st_ff.format[`LOFC_BIT_VS_INV]))
    else $error("vsync active level wrong");
  a_single_select: assert property (
    st_ff.format[`LOFC_BIT_SINGLE] |=> link_state_out == LOFC_LINK_SINGLE)
    else $error("single link not selected");
  a_dual_b_on: assert property (
    link_rise && st_ff.link == LOFC_LINK_DUAL |=> chan_b_out.chan_en)
    else $error("channel B off in dual link");
  a_two_b_on: assert property (
    link_rise && st_ff.link == LOFC_LINK_TWO |=> chan_b_out.chan_en)
    else $error("channel B off in two single links");
  // Register side effects and housekeeping
  a_common_mode_write: assert property (
    reg_wr_in && reg_addr_in == `LOFC_OFS_LEVEL
    |=> chan_a_low_common_mode_out == $past(reg_wdata_in[6])
    && chan_b_low_common_mode_out == $past(reg_wdata_in[4]))
    else $error("common mode select not taken");
  a_swing_write: assert property (
    reg_wr_in && reg_addr_in == `LOFC_OFS_LEVEL
    |=> chan_a_swing_level_out == $past(reg_wdata_in[3:2])
    && chan_b_swing_level_out == $past(reg_wdata_in[1:0]))
    else $error("swing level not taken");
  a_fifo_full_hold: assert property (
    !pix_ready_out && !link_rise |=> !pix_ready_out)
    else $error("FIFO freed a slot without a pop");
  a_rdata_idle_zero: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data stands past its cycle");

  c_dual_link: cover property (link_state_out == LOFC_LINK_DUAL && link_rise && fifo_valid);
  c_two_link: cover property (link_state_out == LOFC_LINK_TWO && link_rise && fifo_valid);
  c_fifo_full: cover property (!pix_ready_out);
  c_reduce_mode: cover property (st_ff.format[`LOFC_BIT_A_LSB] && !st_ff.format[`LOFC_BIT_A_WIDE]
                                 && link_rise && fifo_valid);
  c_reduce_b: cover property (st_ff.format[`LOFC_BIT_B_LSB] && !st_ff.format[`LOFC_BIT_B_WIDE]
                              && st_ff.link != LOFC_LINK_SINGLE && link_rise && fifo_valid);
endmodule : lofc_top
`default_nettype wire

// >>> lofc_panel_model.sv
/*
  Flat panel receiver model: latches both channel words on every link
  clock rising edge. Assumes the block's outputs settle between edges.
*/
`timescale 1ns/10ps
`default_nettype none
module lofc_panel_model
  import lofc_pkg::*;
(
  // Link side
  input  wire logic           link_clk_in,
  input  wire lofc_chan_out_t chan_a_in,
  input  wire lofc_chan_out_t chan_b_in,
  // Captured words
  output var lofc_chan_out_t  seen_a_out,
  output var lofc_chan_out_t  seen_b_out
);
  always_ff @(posedge link_clk_in) begin
    seen_a_out <= chan_a_in;
    seen_b_out <= chan_b_in;
  end
endmodule : lofc_panel_model
`default_nettype wire

// >>> testbench.sv
/*
  Testbench for lofc_top: register access, link modes, pixel formatting
  and FIFO fill. Assumes the panel model and the design files compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lofc_pkg::*;
  logic           clk_in, rst_n_in, link_clk_in, link_run;
  logic [7:0]     reg_addr_in, reg_wdata_in, reg_rdata_out, d, f;
  logic           reg_wr_in, reg_rd_in, pix_valid_in, pix_ready_out;
  lofc_pixel_t    pix_a_in, pix_b_in, pa, pb;
  lofc_chan_out_t chan_a_out, chan_b_out, seen_a, seen_b;
  logic [1:0]     swing_a, swing_b;
  logic           low_a, low_b;
  lofc_link_t     link_state;
  int             n_fail, n_tests, cyc, k, n;
  logic [7:0]     ft[4] = '{8'h78, 8'h8F, 8'h0B, 8'h06};
  logic [7:0]     md[4] = '{8'h01, 8'h00, 8'h02, 8'h01};
  lofc_link_t     lk[4] = '{LOFC_LINK_SINGLE, LOFC_LINK_DUAL, LOFC_LINK_TWO, LOFC_LINK_DUAL};

  lofc_top #(.FIFO_DEPTH(32)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pix_valid_in(pix_valid_in), .pix_a_in(pix_a_in),
    .pix_b_in(pix_b_in), .pix_ready_out(pix_ready_out), .link_clk_in(link_clk_in),
    .chan_a_out(chan_a_out), .chan_b_out(chan_b_out),
    .chan_a_swing_level_out(swing_a), .chan_b_swing_level_out(swing_b),
    .chan_a_low_common_mode_out(low_a), .chan_b_low_common_mode_out(low_b),
    .link_state_out(link_state));
  lofc_panel_model i_panel (.link_clk_in(link_clk_in), .chan_a_in(chan_a_out),
    .chan_b_in(chan_b_out), .seen_a_out(seen_a), .seen_b_out(seen_b));

  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Link clock parks low when stopped
  initial begin
    link_clk_in = 1'h0;
    #7;
    forever begin
      #100;
      if (link_run || link_clk_in) link_clk_in = ~link_clk_in;
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= dt;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1 dt = reg_rdata_out;
  endtask : rd
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // Expected channel word; a disabled channel shows inactive flags only
  function automatic lofc_chan_out_t exp_chan(lofc_pixel_t p, logic wide, logic lsb,
                                              logic en, logic [7:0] fm);
    lofc_chan_out_t e;
    e = '0;
    e.chan_en = en;
    e.data_enable = fm[7] ^ (en & p.data_enable);
    e.hsync = fm[6] ^ (en & p.hsync);
    e.vsync = fm[5] ^ (en & p.vsync);
    if (en) begin
      e.fourth_lane_en = wide;
      e.base_lanes = lsb ? {p.red[7:2], p.green[7:2], p.blue[7:2]}
                         : {p.red[5:0], p.green[5:0], p.blue[5:0]};
      if (wide) e.fourth_lane = lsb ? {p.red[1:0], p.green[1:0], p.blue[1:0]}
                                    : {p.red[7:6], p.green[7:6], p.blue[7:6]};
    end
    return e;
  endfunction : exp_chan

  initial begin
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in, pix_valid_in} = '0;
    pix_a_in = '0;
    pix_b_in = '0;
    rst_n_in = 1'h0;
    link_run = 1'h1;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'h1;
    rd(8'h18, d);
    chk(32'(d), 32'h70);
    chk(32'({low_a, low_b, swing_a, swing_b}), 32'h05);
    rd(8'h19, d);
    chk(32'(d), 32'h05);
    rd(8'h1C, d);
    chk(32'(d), 32'h01);
    rd(8'h00, d);
    chk(32'(d), 32'h00);
    wr(8'h19, 8'hFF);
    rd(8'h19, d);
    chk(32'(d), 32'h5F);
    chk(32'({low_a, low_b, swing_a, swing_b}), 32'h3F);
    // Low common mode on A only; its trim lives outside this block
    wr(8'h19, 8'h40);
    @(posedge clk_in);
    #1 chk(32'({low_a, low_b, swing_a, swing_b}), 32'h20);
    for (k = 0; k < 4; k++) begin
      f = ft[k];
      pa = {8'hC5, 8'h3A, 8'h96, k[0], k[1], ~k[0]};
      pb = {8'h5C, 8'hA3, 8'h69, ~k[0], 1'h1, k[1]};
      // Lane-format bits are also set at 18 bpp in the last two cases, to cover the 24-to-18 reduction
      wr(8'h1C, md[k]);
      wr(8'h18, f);
      @(negedge link_clk_in);
      @(posedge clk_in);
      pix_a_in <= pa;
      pix_b_in <= pb;
      pix_valid_in <= 1'h1;
      @(posedge clk_in);
      pix_valid_in <= 1'h0;
      @(posedge link_clk_in);
      @(posedge link_clk_in);
      #1 chk(32'(seen_a), 32'(exp_chan(pa, f[3], f[1], 1'h1, f)));
      chk(32'(seen_b), 32'(exp_chan(pb, f[2], f[0], ~f[4], f)));
      chk(32'(link_state), 32'(lk[k]));
    end
    // Stall the panel and fill the FIFO until it refuses
    link_run = 1'h0;
    repeat (10) @(posedge clk_in);
    pix_valid_in <= 1'h1;
    n = 0;
    repeat (40) begin
      @(negedge clk_in);
      if (pix_ready_out) n++;
      @(posedge clk_in);
    end
    pix_valid_in <= 1'h0;
    chk(32'(n), 32'd32);
    link_run = 1'h1;
    rd(8'h1D, d);
    for (k = 0; k < 200 && d[3] !== 1'h0; k++) rd(8'h1D, d);
    chk(32'(d), 32'h02);
    conclude();
  end
endmodule : testbench
`default_nettype wire
